// ==== common/osc_switch_pkg.sv ====
// Constants shared by the oscillator switch controller and its testbench.
package osc_switch_pkg;
   // ----------------------------------------
   // Source codes
   // ----------------------------------------
   localparam logic [2:0] SRC_FAST_RC = 3'h0;
   localparam logic [2:0] SRC_FAST_RC_PLL = 3'h1;
   localparam logic [2:0] SRC_PRIMARY = 3'h2;
   localparam logic [2:0] SRC_PRIMARY_PLL = 3'h3;
   localparam logic [2:0] SRC_SECONDARY = 3'h4;
   localparam logic [2:0] SRC_LOW_POWER_RC = 3'h5;
   // ----------------------------------------
   // Unlock keys
   // ----------------------------------------
   localparam logic [31:0] KEY_FIRST = 32'hAA996655;
   localparam logic [31:0] KEY_SECOND = 32'h556699AA;
   // ----------------------------------------
   // Control register field positions and reset values
   // ----------------------------------------
   localparam int CUR_LSB = 12;
   localparam int NEXT_LSB = 8;
   localparam int SEC_EN_BIT = 1;
   localparam int REQ_BIT = 0;
   localparam logic [2:0] NEXT_RESET = 3'h0;
   localparam logic SEC_EN_RESET = 1'b0;
   localparam logic SWITCH_DISABLED = 1'b1;
   // ----------------------------------------
   // Timing
   // ----------------------------------------
   localparam int CLOCK_HZ = 20000000;
   localparam int STARTUP_TIME_US = 50;
   localparam int STARTUP_CYCLES = (STARTUP_TIME_US * (CLOCK_HZ / 1000000) > 0) ?
                                   STARTUP_TIME_US * (CLOCK_HZ / 1000000) : 1;
   localparam int PLL_LOCK_TIMEOUT_CYCLES = 4000;
endpackage

// ==== rtl/osc_wait_timer.sv ====
// Down-counting wait timer with start strobe and one-cycle done pulse.
`timescale 1ns/1ns
module osc_wait_timer #(
   parameter int WIDTH = 16
) (
   input wire logic clock,
   input wire logic rst,
   input wire logic start,
   input wire logic [WIDTH-1:0] load,
   input wire logic abort,
   output logic done,
   output logic busy
);
   typedef struct packed {
      logic [WIDTH-1:0] count;
      logic busy;
      logic done;
   } timer_s;
   timer_s state_q;
   timer_s state_d;

   always_comb begin
      state_d = state_q;
      state_d.done = 1'b0;
      if (abort) begin
         state_d.busy = 1'b0;
         state_d.count = '0;
      end else if (start) begin
         state_d.busy = 1'b1;
         state_d.count = load;
      end else if (state_q.busy) begin
         if (state_q.count <= WIDTH'(1)) begin
            state_d.busy = 1'b0;
            state_d.done = 1'b1;
            state_d.count = '0;
         end else begin
            state_d.count = state_q.count - WIDTH'(1);
         end
      end
   end

   always_ff @(posedge clock) begin
      if (rst) begin
         state_q <= '0;
      end else begin
         state_q <= state_d;
      end
   end

   assign done = state_q.done;
   assign busy = state_q.busy;
endmodule

// ==== rtl/oscillator_switch_controller.sv ====
// Run-time system clock source switch controller with key-unlocked control bits.
`timescale 1ns/1ns
module oscillator_switch_controller #(
   parameter int STARTUP_COUNT = osc_switch_pkg::STARTUP_CYCLES,
   parameter int TIMER_WIDTH = 16
) (
   input wire logic clock,
   input wire logic rst,
   input wire logic switchMonitorCfgBit,
   input wire logic [2:0] initialSourceCfg,
   input wire logic primaryIsCrystal,
   input wire logic oscOutPinFunction,
   input wire logic keyWrite,
   input wire logic [31:0] keyData,
   input wire logic ctrlWrite,
   input wire logic [2:0] nextSourceWrData,
   input wire logic requestWrData,
   input wire logic secEnableWrData,
   input wire logic sleepEntry,
   input wire logic failSafeEvent,
   input wire logic [7:0] sourceRunning,
   input wire logic [7:0] sourceUsedByOthers,
   input wire logic pllLock,
   output logic registerLockState,
   output logic [2:0] currentSourceStatus,
   output logic [2:0] nextSourceSel,
   output logic switchRequestBit,
   output logic secondaryOscEnable,
   output logic [7:0] sourceEnable,
   output logic [2:0] systemClockSel,
   output logic primaryInPinIsOsc,
   output logic primaryOutPinIsOsc,
   output logic primaryOutPinIsClock,
   output logic secondaryPinsAreOsc
);
   // ----------------------------------------
   // State
   // ----------------------------------------
   typedef enum logic [1:0] {LOCKED, KEY1_SEEN, UNLOCKED} lock_e;
   typedef enum logic [2:0] {IDLE, START, WAIT_STARTUP, WAIT_LOCK, COMMIT} sw_e;
   typedef struct packed {
      lock_e lock;
      sw_e sw;
      logic [2:0] cur;
      logic [2:0] nxt;
      logic req;
      logic secEn;
      logic [7:0] srcEn;
      logic inOsc;
      logic outOsc;
      logic outClk;
      logic secPins;
      logic boot;
      logic lockedOut;
      logic [7:0] runMeta;
      logic [7:0] runSync;
      logic pllMeta;
      logic pllSync;
   } ctl_s;
   ctl_s s_q;
   ctl_s s_d;

   logic timerStart;
   logic timerDone;
   logic timerBusy;
   logic switchEnabled;
   logic unlocked;
   logic [2:0] target;
   logic targetPll;
   logic curPll;
   logic [7:0] needed;

   assign switchEnabled = (switchMonitorCfgBit == 1'b0);
   assign unlocked = (s_q.lock == UNLOCKED);
   assign target = s_q.nxt;
   assign targetPll = (target == osc_switch_pkg::SRC_FAST_RC_PLL) ||
                      (target == osc_switch_pkg::SRC_PRIMARY_PLL);
   assign curPll = (s_q.cur == osc_switch_pkg::SRC_FAST_RC_PLL) ||
                   (s_q.cur == osc_switch_pkg::SRC_PRIMARY_PLL);

   osc_wait_timer #(
      .WIDTH(TIMER_WIDTH)
   ) u_startup (
      .clock(clock),
      .rst(rst),
      .start(timerStart),
      .load(TIMER_WIDTH'(STARTUP_COUNT)),
      .abort(s_q.sw == IDLE),
      .done(timerDone),
      .busy(timerBusy)
   );

   // ----------------------------------------
   // Next state
   // ----------------------------------------
   always_comb begin
      s_d = s_q;
      timerStart = 1'b0;
      needed = '0;
      // Oscillator status comes from free-running analogue parts, so only the second stage is
      // read; a switch therefore sees a new running or lock level two cycles late.
      s_d.runMeta = sourceRunning;
      s_d.runSync = s_q.runMeta;
      s_d.pllMeta = pllLock;
      s_d.pllSync = s_q.pllMeta;
      // Unlock sequence; a stray value always relocks.
      if (keyWrite) begin
         if (keyData == osc_switch_pkg::KEY_FIRST) begin
            s_d.lock = KEY1_SEEN;
         end else if (keyData == osc_switch_pkg::KEY_SECOND && s_q.lock == KEY1_SEEN) begin
            s_d.lock = UNLOCKED;
         end else begin
            s_d.lock = LOCKED;
         end
      end
      // Software writes take effect only while unlocked.
      if (ctrlWrite && unlocked) begin
         s_d.nxt = nextSourceWrData;
         s_d.secEn = secEnableWrData;
         if (requestWrData && switchEnabled && s_q.sw == IDLE) begin
            s_d.req = 1'b1;
         end
      end
      unique case (s_q.sw)
         IDLE: begin
            if (s_q.req) begin
               if (s_q.nxt == s_q.cur) begin
                  s_d.req = 1'b0;
               end else if (targetPll && curPll) begin
                  s_d.req = 1'b0;
               end else begin
                  s_d.sw = START;
               end
            end
         end
         START: begin
            // Waits while the target is absent; request stays set meanwhile.
            if (s_q.runSync[target]) begin
               if ((target == osc_switch_pkg::SRC_PRIMARY ||
                    target == osc_switch_pkg::SRC_PRIMARY_PLL) && primaryIsCrystal) begin
                  timerStart = 1'b1;
                  s_d.sw = WAIT_STARTUP;
               end else begin
                  s_d.sw = targetPll ? WAIT_LOCK : COMMIT;
               end
            end
         end
         WAIT_STARTUP: begin
            if (timerDone) begin
               s_d.sw = targetPll ? WAIT_LOCK : COMMIT;
            end
         end
         WAIT_LOCK: begin
            if (s_q.pllSync) begin
               s_d.sw = COMMIT;
            end
         end
         COMMIT: begin
            s_d.cur = s_q.nxt;
            s_d.req = 1'b0;
            s_d.sw = IDLE;
         end
         default: begin
            s_d.sw = IDLE;
         end
      endcase
      // Sleep aborts a pending switch and keeps the old source.
      if (sleepEntry && s_q.sw != IDLE) begin
         s_d.sw = IDLE;
         s_d.req = 1'b0;
         s_d.cur = s_q.cur;
      end
      if (failSafeEvent && switchEnabled) begin
         s_d.cur = osc_switch_pkg::SRC_FAST_RC;
         s_d.req = 1'b0;
         s_d.sw = IDLE;
      end
      if (!switchEnabled) begin
         s_d.req = 1'b0;
         s_d.sw = IDLE;
         s_d.cur = initialSourceCfg;
      end
      if (s_q.boot) begin
         s_d.cur = initialSourceCfg;
         s_d.boot = 1'b0;
      end
      // Oscillator enables: current source, pending target, helpers, secondary.
      needed[s_d.cur] = 1'b1;
      if (s_d.sw != IDLE) begin
         needed[s_d.nxt] = 1'b1;
      end
      needed = needed | sourceUsedByOthers;
      if (s_d.secEn) begin
         needed[osc_switch_pkg::SRC_SECONDARY] = 1'b1;
      end
      s_d.srcEn = needed;
      // Primary pin functions follow the active source; secondary pins follow the secondary source's bit of the oscillator enables.
      s_d.inOsc = (s_d.cur == osc_switch_pkg::SRC_PRIMARY ||
                   s_d.cur == osc_switch_pkg::SRC_PRIMARY_PLL);
      s_d.outOsc = s_d.inOsc && primaryIsCrystal;
      s_d.outClk = !s_d.outOsc && oscOutPinFunction;
      s_d.secPins = needed[osc_switch_pkg::SRC_SECONDARY];
      s_d.lockedOut = (s_d.lock != UNLOCKED);
   end

   // ----------------------------------------
   // Registers
   // ----------------------------------------
   always_ff @(posedge clock) begin
      if (rst) begin
         s_q.lock <= LOCKED;
         s_q.sw <= IDLE;
         s_q.cur <= osc_switch_pkg::SRC_FAST_RC;
         s_q.nxt <= osc_switch_pkg::NEXT_RESET;
         s_q.req <= 1'b0;
         s_q.secEn <= osc_switch_pkg::SEC_EN_RESET;
         s_q.srcEn <= 8'h01;
         s_q.inOsc <= 1'b0;
         s_q.outOsc <= 1'b0;
         s_q.outClk <= 1'b0;
         s_q.secPins <= 1'b0;
         s_q.boot <= 1'b1;
         s_q.lockedOut <= 1'b1;
         s_q.runMeta <= 8'h00;
         s_q.runSync <= 8'h00;
         s_q.pllMeta <= 1'b0;
         s_q.pllSync <= 1'b0;
      end else begin
         s_q <= s_d;
      end
   end

   // The old source keeps clocking the core through the commit cycle.
   assign registerLockState = s_q.lockedOut;
   assign currentSourceStatus = s_q.cur;
   assign systemClockSel = s_q.cur;
   assign nextSourceSel = s_q.nxt;
   assign switchRequestBit = s_q.req;
   assign secondaryOscEnable = s_q.secEn;
   assign sourceEnable = s_q.srcEn;
   assign primaryInPinIsOsc = s_q.inOsc;
   assign primaryOutPinIsOsc = s_q.outOsc;
   assign primaryOutPinIsClock = s_q.outClk;
   assign secondaryPinsAreOsc = s_q.secPins;

   // ----------------------------------------
   // Checks
   // ----------------------------------------
   a_req_held_off: assert property (@(posedge clock) disable iff (rst)
      switchMonitorCfgBit |=> !switchRequestBit) else $error("request set while disabled");
   a_cur_follows_cfg: assert property (@(posedge clock) disable iff (rst)
      switchMonitorCfgBit ##1 switchMonitorCfgBit
      |-> currentSourceStatus == $past(initialSourceCfg))
      else $error("current source not from config");
   a_unlock_pair: assert property (@(posedge clock) disable iff (rst)
      keyWrite && keyData == osc_switch_pkg::KEY_FIRST ##1
      keyWrite && keyData == osc_switch_pkg::KEY_SECOND |=> !registerLockState)
      else $error("key pair did not unlock");
   a_relock_stray: assert property (@(posedge clock) disable iff (rst)
      keyWrite && keyData != osc_switch_pkg::KEY_FIRST && keyData != osc_switch_pkg::KEY_SECOND
      |=> registerLockState) else $error("stray key did not relock");
   a_locked_ignore: assert property (@(posedge clock) disable iff (rst)
      registerLockState && !keyWrite |=> $stable(nextSourceSel) && $stable(secondaryOscEnable))
      else $error("locked field changed");
   a_redundant_clear: assert property (@(posedge clock) disable iff (rst || sleepEntry)
      s_q.sw == IDLE && switchRequestBit && nextSourceSel == currentSourceStatus && !failSafeEvent
      |=> !switchRequestBit) else $error("redundant request kept");
   a_pll_refused: assert property (@(posedge clock) disable iff (rst)
      s_q.sw == IDLE && switchRequestBit && curPll && targetPll |=> s_q.sw == IDLE)
      else $error("PLL to PLL switch started");
   a_sleep_abort: assert property (@(posedge clock) disable iff (rst)
      sleepEntry && s_q.sw != IDLE && !failSafeEvent && !switchMonitorCfgBit
      |=> !switchRequestBit && $stable(currentSourceStatus)) else $error("sleep did not abort");
   a_commit_copy: assert property (@(posedge clock) disable iff (rst)
      s_q.sw == COMMIT && !failSafeEvent && !switchMonitorCfgBit && !sleepEntry
      |=> currentSourceStatus == $past(nextSourceSel) && !switchRequestBit)
      else $error("commit did not copy");
   a_sec_running: assert property (@(posedge clock) disable iff (rst)
      secondaryOscEnable |-> sourceEnable[osc_switch_pkg::SRC_SECONDARY])
      else $error("secondary oscillator off while enabled");
   a_startup_wait: assert property (@(posedge clock) disable iff (rst)
      s_q.sw == WAIT_STARTUP |-> timerBusy || timerDone)
      else $error("start-up timer idle while waiting");
endmodule

// ==== verification/testbench.sv ====
// Self-checking bench for the oscillator switch controller.
`timescale 1ns/1ns
`define CHK(what, exp, got) begin checksDone++; if ((got) !== (exp)) begin nFail++; \
   $display("unexpected %s expected %0h seen %0h", what, exp, got); end end
module testbench;
   // ----------------------------------------
   // Signals
   // ----------------------------------------
   // A short start-up count keeps the crystal waits brief.
   localparam int STARTUP = 4;
   localparam int LIMIT = 6000;
   logic clock = 1'b0;
   logic rst = 1'b1;
   logic switchMonitorCfgBit = 1'b1;
   logic [2:0] initialSourceCfg = 3'h0;
   logic primaryIsCrystal = 1'b0;
   logic oscOutPinFunction = 1'b0;
   logic keyWrite = 1'b0;
   logic [31:0] keyData = 32'h0;
   logic ctrlWrite = 1'b0;
   logic [2:0] nextSourceWrData = 3'h0;
   logic requestWrData = 1'b0;
   logic secEnableWrData = 1'b0;
   logic sleepEntry = 1'b0;
   logic failSafeEvent = 1'b0;
   logic [7:0] sourceRunning = 8'hFF;
   logic [7:0] sourceUsedByOthers = 8'h00;
   logic pllLock = 1'b0;
   logic registerLockState;
   logic [2:0] currentSourceStatus;
   logic [2:0] nextSourceSel;
   logic switchRequestBit;
   logic secondaryOscEnable;
   logic [7:0] sourceEnable;
   logic [2:0] systemClockSel;
   logic primaryInPinIsOsc;
   logic primaryOutPinIsOsc;
   logic primaryOutPinIsClock;
   logic secondaryPinsAreOsc;
   int nFail = 0;
   int checksDone = 0;
   int cycles = 0;
   always #25 clock = ~clock;
   oscillator_switch_controller #(.STARTUP_COUNT(STARTUP)) i_dut (
      .clock(clock), .rst(rst), .switchMonitorCfgBit(switchMonitorCfgBit),
      .initialSourceCfg(initialSourceCfg), .primaryIsCrystal(primaryIsCrystal),
      .oscOutPinFunction(oscOutPinFunction), .keyWrite(keyWrite), .keyData(keyData),
      .ctrlWrite(ctrlWrite), .nextSourceWrData(nextSourceWrData),
      .requestWrData(requestWrData), .secEnableWrData(secEnableWrData),
      .sleepEntry(sleepEntry), .failSafeEvent(failSafeEvent), .sourceRunning(sourceRunning),
      .sourceUsedByOthers(sourceUsedByOthers), .pllLock(pllLock),
      .registerLockState(registerLockState), .currentSourceStatus(currentSourceStatus),
      .nextSourceSel(nextSourceSel), .switchRequestBit(switchRequestBit),
      .secondaryOscEnable(secondaryOscEnable), .sourceEnable(sourceEnable),
      .systemClockSel(systemClockSel), .primaryInPinIsOsc(primaryInPinIsOsc),
      .primaryOutPinIsOsc(primaryOutPinIsOsc), .primaryOutPinIsClock(primaryOutPinIsClock),
      .secondaryPinsAreOsc(secondaryPinsAreOsc));
   // ----------------------------------------
   // Helpers
   // ----------------------------------------
   task automatic step(input int n);
      repeat (n) @(posedge clock);
      #1;
   endtask
   task automatic doReset(input logic cfg, input logic [2:0] init);
      switchMonitorCfgBit = cfg;
      initialSourceCfg = init;
      rst = 1'b1;
      step(2);
      rst = 1'b0;
      step(1);
   endtask
   // The two writes go on consecutive edges; the unlock only needs no other key write between them.
   task automatic keys(input logic [31:0] a, input logic [31:0] b);
      keyWrite = 1'b1;
      keyData = a;
      step(1);
      keyData = b;
      step(1);
      keyWrite = 1'b0;
      step(1);
   endtask
   task automatic ctrl(input logic [2:0] nxt, input logic req, input logic sec);
      ctrlWrite = 1'b1;
      nextSourceWrData = nxt;
      requestWrData = req;
      secEnableWrData = sec;
      step(1);
      ctrlWrite = 1'b0;
      step(1);
   endtask
   task automatic pulse(input logic sel);
      if (sel) sleepEntry = 1'b1;
      else failSafeEvent = 1'b1;
      step(1);
      sleepEntry = 1'b0;
      failSafeEvent = 1'b0;
      step(1);
   endtask
   task automatic waitIdle(input int limit, output int n);
      n = 0;
      while (switchRequestBit !== 1'b0 && n < limit) begin
         step(1);
         n++;
      end
   endtask
   function automatic logic isPll(input logic [2:0] s);
      return s == osc_switch_pkg::SRC_FAST_RC_PLL || s == osc_switch_pkg::SRC_PRIMARY_PLL;
   endfunction
   function automatic logic isPrimary(input logic [2:0] s);
      return s == osc_switch_pkg::SRC_PRIMARY || s == osc_switch_pkg::SRC_PRIMARY_PLL;
   endfunction
   // Current source, other users and the secondary enable keep their oscillators on.
   function automatic logic [7:0] expEn(input logic [2:0] c, input logic s, input logic [7:0] o);
      logic [7:0] e;
      e = o;
      e[c] = 1'b1;
      if (s) e[osc_switch_pkg::SRC_SECONDARY] = 1'b1;
      return e;
   endfunction
   // A switch between two PLL sources is refused, so the old source stays.
   function automatic logic [2:0] expCur(input logic [2:0] cur, input logic [2:0] nxt);
      return (isPll(cur) && isPll(nxt)) ? cur : nxt;
   endfunction
   task automatic tally_and_finish;
      $display("checks %0d mismatches %0d", checksDone, nFail);
      if (nFail == 0 && checksDone > 0) begin
         $display("TEST PASSED");
      end else begin
         $display("TEST FAILED");
      end
      $finish;
   endtask
   always @(posedge clock) begin
      cycles++;
      if (cycles == LIMIT) begin
         nFail++;
         tally_and_finish();
      end
   end
   // ----------------------------------------
   // Scenarios
   // ----------------------------------------
   initial begin
      int n;
      logic [2:0] cur;
      logic [2:0] nxt;
      logic sec;
      logic outOsc;
      void'($urandom(47981));
      doReset(1'b1, 3'h2);
      `CHK("cur from config", 3'h2, currentSourceStatus)
      keys(osc_switch_pkg::KEY_FIRST, osc_switch_pkg::KEY_SECOND);
      ctrl(3'h4, 1'b1, 1'b0);
      `CHK("req disabled", 1'b0, switchRequestBit)
      step(10);
      `CHK("cur disabled", 3'h2, systemClockSel)
      doReset(1'b0, 3'h0);
      ctrl(3'h4, 1'b1, 1'b1);
      `CHK("locked next", 3'h0, nextSourceSel)
      `CHK("locked req", 1'b0, switchRequestBit)
      keys(osc_switch_pkg::KEY_FIRST, 32'h12345678);
      `CHK("bad second key", 1'b1, registerLockState)
      keys(osc_switch_pkg::KEY_FIRST, osc_switch_pkg::KEY_SECOND);
      `CHK("unlocked", 1'b0, registerLockState)
      step(20);
      `CHK("stays unlocked", 1'b0, registerLockState)
      ctrl(3'h4, 1'b1, 1'b0);
      `CHK("req pending", 1'b1, switchRequestBit)
      `CHK("old clock", 3'h0, systemClockSel)
      waitIdle(10, n);
      `CHK("cur secondary", 3'h4, currentSourceStatus)
      `CHK("sec pins", 1'b1, secondaryPinsAreOsc)
      `CHK("sec used", 1'b1, sourceEnable[4])
      ctrl(3'h4, 1'b1, 1'b0);
      `CHK("redundant req", 1'b0, switchRequestBit)
      sourceRunning = 8'hFB;
      ctrl(3'h2, 1'b1, 1'b0);
      pulse(1'b0);
      `CHK("fail-safe cur", 3'h0, currentSourceStatus)
      `CHK("fail-safe req", 1'b0, switchRequestBit)
      step(2);
      `CHK("old source off", 1'b0, sourceEnable[4])
      ctrl(3'h0, 1'b0, 1'b1);
      pulse(1'b1);
      `CHK("sec enabled", 1'b1, sourceEnable[4])
      ctrl(3'h2, 1'b1, 1'b0);
      step(30);
      `CHK("absent target req", 1'b1, switchRequestBit)
      `CHK("absent target cur", 3'h0, systemClockSel)
      `CHK("target started", 1'b1, sourceEnable[2])
      pulse(1'b1);
      `CHK("sleep abort req", 1'b0, switchRequestBit)
      `CHK("sleep abort cur", 3'h0, currentSourceStatus)
      sourceRunning = 8'hFF;
      primaryIsCrystal = 1'b1;
      ctrl(3'h3, 1'b1, 1'b0);
      step(STARTUP + 10);
      `CHK("pll wait", 1'b1, switchRequestBit)
      pllLock = 1'b1;
      waitIdle(STARTUP + 20, n);
      `CHK("cur pll", 3'h3, currentSourceStatus)
      ctrl(3'h1, 1'b1, 1'b0);
      waitIdle(5, n);
      `CHK("pll to pll", 3'h3, currentSourceStatus)
      ctrl(3'h0, 1'b1, 1'b0);
      waitIdle(STARTUP + 20, n);
      ctrl(3'h2, 1'b1, 1'b0);
      waitIdle(STARTUP + 20, n);
      `CHK("start-up wait", 1'b1, n >= STARTUP)
      `CHK("primary pin", 1'b1, primaryInPinIsOsc)
      cur = 3'h2;
      // The fail-safe input stays quiet here, so a slow target never meets a false failure.
      repeat (16) begin
         nxt = 3'($urandom_range(5, 0));
         sec = 1'($urandom);
         primaryIsCrystal = 1'($urandom);
         oscOutPinFunction = 1'($urandom);
         sourceUsedByOthers = 8'($urandom);
         ctrl(nxt, 1'b1, sec);
         waitIdle(STARTUP + 20, n);
         cur = expCur(cur, nxt);
         outOsc = isPrimary(cur) && primaryIsCrystal;
         `CHK("random cur", cur, currentSourceStatus)
         `CHK("random req", 1'b0, switchRequestBit)
         `CHK("random next", nxt, nextSourceSel)
         `CHK("random sec", sec, secondaryOscEnable)
         `CHK("random enables", expEn(cur, sec, sourceUsedByOthers), sourceEnable)
         `CHK("random in pin", isPrimary(cur), primaryInPinIsOsc)
         `CHK("random out osc", outOsc, primaryOutPinIsOsc)
         `CHK("random out clk", !outOsc && oscOutPinFunction, primaryOutPinIsClock)
      end
      keys(32'h12345678, 32'h12345678);
      `CHK("relocked", 1'b1, registerLockState)
      tally_and_finish();
   end
endmodule
